// ### verilog/epp_prog_access.sv
/*
  programming-mode access logic for a 4096 x 16 program memory with a
  erasable read-protect cell, plus a small three-stage pin synchroniser.
  assumes the programmer holds address and data stable from before a strobe
  edge until the edge has been seen (a few clocks), and drives all pins
  asynchronously to clk.
*/
// How it works
// - memory holds 4096 words of 16 bits, each writable by the programmer.
// - each word arrives as two bytes, high byte first, then low byte.
// - a full erase sets every bit of every word to one.
// - set protect cell blocks array readout and external-program mode.
// - protect cell survives resets; only a full erase clears it.
// - words may be written singly, in blocks or in any address order.
`timescale 1ns/1ns

// ------------------------------------------------------------------
// pin synchroniser: three stages plus an output flop, a bit changes once stages two and three agree
// ------------------------------------------------------------------
module epp_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,     // system clock
  input  wire logic             sys_rst, // async reset, high
  input  wire logic [WIDTH-1:0] pin,     // raw asynchronous pins
  output logic      [WIDTH-1:0] level_q  // filtered level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
    end
  end
endmodule

// ------------------------------------------------------------------
// programming access top
// ------------------------------------------------------------------
module epp_prog_access #(
  parameter int ADDR_W = epp_pkg::ADDR_W,
  parameter int BYTE_W = epp_pkg::BYTE_W
) (
  input  wire logic              clk,          // 25 MHz clock
  input  wire logic              sys_rst,      // async reset, high
  input  wire logic              pgm_mode,     // programming mode select pin
  input  wire logic              pgm_strobe,   // byte load strobe pin, rising edge
  input  wire logic [ADDR_W-1:0] pgm_addr,     // word address pins
  input  wire logic [BYTE_W-1:0] pgm_data,     // byte data pins
  input  wire logic              pgm_read,     // read/verify request pin, level
  input  wire logic              pgm_erase,    // full erase request pin, rising edge
  input  wire logic              pgm_protect,  // protect-cell program pin, rising edge
  input  wire logic              mp_mode_req,  // external-program mode request pin
  output logic [2*BYTE_W-1:0]    rd_data_q,    // read/verify word
  output logic                   rd_valid_q,   // read word updated this cycle
  output logic                   erase_busy,   // erase sweep in progress
  output logic                   protected_q,  // read-protect cell state
  output logic                   mp_mode_en_q  // external-program mode granted
);
  localparam int WORD_W = 2 * BYTE_W;
  localparam int DEPTH  = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);

  if (WORD_W != epp_pkg::WORD_W || DEPTH != epp_pkg::ERASE_CYCLES) begin : g_bad_geometry
    $error("epp_prog_access: geometry must be 4096 words of two bytes");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------------
  logic [5:0]        ctl_s;
  logic [ADDR_W-1:0] addr_s;
  logic [BYTE_W-1:0] data_s;
  logic [2:0]        edge_prev_q;

  epp_pin_sync #(.WIDTH(6)) u_sync_ctl (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     ({pgm_mode, pgm_strobe, pgm_read, pgm_erase, pgm_protect, mp_mode_req}),
    .level_q (ctl_s)
  );
  epp_pin_sync #(.WIDTH(ADDR_W)) u_sync_addr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (pgm_addr),
    .level_q (addr_s)
  );
  epp_pin_sync #(.WIDTH(BYTE_W)) u_sync_data (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (pgm_data),
    .level_q (data_s)
  );

  wire mode_s    = ctl_s[5];
  wire strobe_s  = ctl_s[4];
  wire read_s    = ctl_s[3];
  wire erase_s   = ctl_s[2];
  wire protect_s = ctl_s[1];
  wire mp_req_s  = ctl_s[0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_prev_q <= 3'h0;
    end else begin
      edge_prev_q <= {strobe_s, erase_s, protect_s};
    end
  end

  wire byte_go    = mode_s & strobe_s & ~edge_prev_q[2];
  wire erase_go   = mode_s & erase_s & ~edge_prev_q[1];
  wire protect_go = mode_s & protect_s & ~edge_prev_q[0];

  // ------------------------------------------------------------------
  // byte pairing and erase sequencer
  // ------------------------------------------------------------------
  epp_pkg::epp_state_t state_q;
  logic [BYTE_W-1:0]   hi_q;
  logic [ADDR_W-1:0]   sweep_q;

  wire erasing    = (state_q == epp_pkg::st_erase);
  wire erase_done = erasing & (sweep_q == LAST_ADDR);
  wire word_go    = (state_q == epp_pkg::st_low) & byte_go;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= epp_pkg::st_idle;
      hi_q    <= epp_pkg::HI_RST_BYTE;
      sweep_q <= '0;
    end else begin
      case (state_q)
        epp_pkg::st_idle: begin
          if (erase_go) begin
            state_q <= epp_pkg::st_erase;
            sweep_q <= '0;
          end else if (byte_go) begin
            hi_q    <= data_s;
            state_q <= epp_pkg::st_low;
          end
        end
        epp_pkg::st_low: begin
          if (erase_go) begin
            state_q <= epp_pkg::st_erase;
            sweep_q <= '0;
          end else if (!mode_s || byte_go) begin
            state_q <= epp_pkg::st_idle;
          end
        end
        epp_pkg::st_erase: begin
          sweep_q <= sweep_q + 1'b1;
          if (erase_done) begin
            state_q <= epp_pkg::st_idle;
          end
        end
        default: state_q <= epp_pkg::st_idle;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // array; any address may be written at any time, so no order is kept
  // ------------------------------------------------------------------
  // power-up models an erased, unprotected part; the array and the cell are
  // nonvolatile, so sys_rst deliberately touches neither
  logic [WORD_W-1:0] mem [DEPTH] = '{default: epp_pkg::ERASED_WORD};
  logic              cell_q      = 1'b0;

  wire              mem_we = word_go | erasing;
  wire [ADDR_W-1:0] mem_wa = erasing ? sweep_q : addr_s;
  wire [WORD_W-1:0] mem_wd = erasing ? epp_pkg::ERASED_WORD : {hi_q, data_s};
  wire [WORD_W-1:0] mem_rd = mem[addr_s];

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // set wins over the clear at the last erase cycle
  always_ff @(posedge clk) begin
    cell_q <= protect_go | (cell_q & ~erase_done);
  end

  // ------------------------------------------------------------------
  // readout and mode grant
  // ------------------------------------------------------------------
  wire rd_go = mode_s & read_s & ~erasing;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q    <= epp_pkg::RD_RST_WORD;
      rd_valid_q   <= 1'b0;
      mp_mode_en_q <= 1'b0;
    end else begin
      rd_valid_q   <= rd_go;
      if (rd_go) begin
        rd_data_q <= cell_q ? epp_pkg::PROTECT_WORD : mem_rd;
      end
      mp_mode_en_q <= mp_req_s & ~mode_s & ~cell_q;
    end
  end

  assign erase_busy  = erasing;
  assign protected_q = cell_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_mp_mode_block: assert property (cell_q |=> !mp_mode_en_q)
    else $error("external mode granted while protected");
  chk_read_masked: assert property (rd_go && cell_q |=> rd_data_q == epp_pkg::PROTECT_WORD)
    else $error("protected read leaked array data");
  chk_read_open: assert property (rd_go && !cell_q |=> rd_data_q == $past(mem_rd) && rd_valid_q)
    else $error("unprotected read returned wrong word");
  chk_byte_order: assert property (state_q == epp_pkg::st_idle && byte_go && !erase_go
                                   |=> state_q == epp_pkg::st_low && hi_q == $past(data_s))
    else $error("high byte not captured first");
  chk_word_write: assert property (word_go && !erase_go |=> mem[$past(addr_s)] == {$past(hi_q), $past(data_s)})
    else $error("assembled word not stored at its address");
  chk_erase_ones: assert property (erasing |=> mem[$past(sweep_q)] == epp_pkg::ERASED_WORD)
    else $error("erased word not all ones");
  chk_erase_end: assert property (erase_done && !protect_go |=> !cell_q && state_q == epp_pkg::st_idle)
    else $error("erase end did not clear protect cell");
  chk_cell_sticky: assert property (cell_q && !erase_done |=> cell_q)
    else $error("protect cell dropped without erase");
  chk_erase_length: assert property (erase_go && !erasing |=> erasing [*8])
    else $error("erase sweep ended early");

  cov_word_write:   cover property (word_go);
  cov_erase_done:   cover property (erase_done);
  cov_protect_read: cover property (rd_go && cell_q);
  cov_protect_set:  cover property (!cell_q ##1 cell_q);
endmodule

// ### verilog/epp_pkg.sv
/*
  shared constants and types for the program-memory programming-mode access logic.
  assumes a single 25 MHz clock and an external programmer driving slow, held pins.
*/
package epp_pkg;
  // ------------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int DEPTH  = 4096;

  // ------------------------------------------------------------------
  // values
  // ------------------------------------------------------------------
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
  localparam logic [15:0] PROTECT_WORD = 16'h0000;
  localparam logic [15:0] RD_RST_WORD  = 16'h0000;
  localparam logic [7:0]  HI_RST_BYTE  = 8'h00;
  localparam int          SYNC_STAGES  = 3;
  localparam int          CLK_HZ       = 25000000;
  localparam int          ERASE_CYCLES = DEPTH;

  // ------------------------------------------------------------------
  // programming sequencer states, gray along idle -> low byte -> idle
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle  = 2'h0,
    st_low   = 2'h1,
    st_erase = 2'h3
  } epp_state_t;
endpackage

// ### dv/epp_prog_model.sv
/*
  programmer model: drives the programming pins of the access block and reads back.
  assumes one free-running clk and that tasks are called one at a time.
*/
`timescale 1ns/1ns
module epp_prog_model (
  input  wire logic        clk,         // system clock
  input  wire logic [15:0] rd_word,     // read word from device
  input  wire logic        rd_ok,       // read valid from device
  output logic             pgm_mode,    // mode select
  output logic             pgm_strobe,  // byte strobe
  output logic [11:0]      pgm_addr,    // word address
  output logic [7:0]       pgm_data,    // byte data
  output logic             pgm_read,    // read request
  output logic             pgm_erase,   // erase request
  output logic             pgm_protect  // protect request
);
  // no signature readout task exists, so no address pin ever carries one
  initial begin
    {pgm_mode, pgm_strobe, pgm_read, pgm_erase, pgm_protect} = 5'h10;
    pgm_addr = 12'h000;
    pgm_data = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data held through the strobe-high time, then inverted as a released bus
  task automatic send_byte(input logic [7:0] b, input int slow);
    pgm_data <= b;
    hold(1 + slow);
    pgm_strobe <= 1'b1;
    hold(6 + slow);
    pgm_strobe <= 1'b0;
    hold(6);
    pgm_data <= ~b;
    hold(1);
  endtask

  task automatic write_word(input logic [11:0] a, input logic [15:0] w, input int slow);
    pgm_addr <= a;
    send_byte(w[15:8], slow);
    send_byte(w[7:0], slow);
  endtask

  task automatic read_word(input logic [11:0] a, output logic [15:0] w, output logic v);
    pgm_addr <= a;
    hold(2);
    pgm_read <= 1'b1;
    hold(8);
    #1;
    w = rd_word;
    v = rd_ok;
    @(posedge clk);
    pgm_read <= 1'b0;
    hold(6);
  endtask

  task automatic pulse_ctl(input bit er);
    pgm_erase   <= er;
    pgm_protect <= !er;
    hold(6);
    pgm_erase <= 1'b0;
    pgm_protect <= 1'b0;
    hold(6);
  endtask

  task automatic set_mode(input logic m);
    pgm_mode <= m;
    hold(8);
  endtask
endmodule

// ### dv/eprom_program_protect_logic_tb.sv
/*
  self-checking bench for the programming access block with a programmer model.
  assumes the device powers up erased and unprotected.
*/
`timescale 1ns/1ns
module eprom_program_protect_logic_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        mp_mode_req = 1'b0;
  logic        pgm_mode, pgm_strobe, pgm_read, pgm_erase, pgm_protect;
  logic [11:0] pgm_addr;
  logic [7:0]  pgm_data;
  logic [15:0] rd_data_q, w;
  logic        rd_valid_q, erase_busy, protected_q, mp_mode_en_q, v, prot_exp;
  logic [15:0] ref_mem [0:4095];
  logic [11:0] used [$];
  int          err_total = 0;
  int          n_tests = 0;

  always #20 clk = ~clk;

  epp_prog_access i_epp_prog_access (.clk(clk), .sys_rst(sys_rst), .pgm_mode(pgm_mode),
    .pgm_strobe(pgm_strobe), .pgm_addr(pgm_addr), .pgm_data(pgm_data), .pgm_read(pgm_read),
    .pgm_erase(pgm_erase), .pgm_protect(pgm_protect), .mp_mode_req(mp_mode_req),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .erase_busy(erase_busy),
    .protected_q(protected_q), .mp_mode_en_q(mp_mode_en_q));

  epp_prog_model i_epp_prog_model (.clk(clk), .rd_word(rd_data_q), .rd_ok(rd_valid_q),
    .pgm_mode(pgm_mode), .pgm_strobe(pgm_strobe), .pgm_addr(pgm_addr), .pgm_data(pgm_data),
    .pgm_read(pgm_read), .pgm_erase(pgm_erase), .pgm_protect(pgm_protect));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_rd(input logic [11:0] x);
    return prot_exp ? epp_pkg::PROTECT_WORD : ref_mem[x];
  endfunction

  task automatic do_write(input logic [11:0] x, input logic [15:0] d);
    i_epp_prog_model.write_word(x, d, $urandom_range(0, 3));
    ref_mem[x] = d;
    used.push_back(x);
  endtask

  task automatic do_read(input logic [11:0] x);
    i_epp_prog_model.read_word(x, w, v);
    check("read word", w, exp_rd(x));
    check("read valid", {15'h0000, v}, 16'h0001);
  endtask

  task automatic check_flag(input string what, input logic f, input logic e);
    check(what, {15'h0000, f}, {15'h0000, e});
  endtask

  initial begin
    void'($urandom(94));
    prot_exp = 1'b0;
    foreach (ref_mem[i]) ref_mem[i] = epp_pkg::ERASED_WORD;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 check_flag("cell at power-up", protected_q, 1'b0);
    do_read(12'h7A3);
    do_write(12'hFFF, 16'hA55A);
    do_write(12'h000, 16'h00FF);
    for (int i = 0; i < 4; i++) do_write(12'h100 + 12'(i), 16'($urandom));
    for (int i = 0; i < 8; i++) do_write(12'($urandom), 16'($urandom));
    do_write(12'hFFF, 16'h0001);
    foreach (used[i]) do_read(used[i]);
    // a lone high byte followed by a mode drop must not pair with the next word
    i_epp_prog_model.send_byte(8'hC3, 0);
    i_epp_prog_model.set_mode(1'b0);
    i_epp_prog_model.set_mode(1'b1);
    do_write(12'h2A5, 16'h1234);
    do_read(12'h2A5);
    i_epp_prog_model.set_mode(1'b0);
    mp_mode_req <= 1'b1;
    repeat (10) @(posedge clk);
    #1 check_flag("external mode granted", mp_mode_en_q, 1'b1);
    i_epp_prog_model.set_mode(1'b1);
    i_epp_prog_model.pulse_ctl(1'b0);
    prot_exp = 1'b1;
    check_flag("cell after protect", protected_q, 1'b1);
    do_read(12'hFFF);
    do_read(used[2]);
    i_epp_prog_model.set_mode(1'b0);
    repeat (10) @(posedge clk);
    #1 check_flag("external mode refused", mp_mode_en_q, 1'b0);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 check_flag("cell through reset", protected_q, 1'b1);
    i_epp_prog_model.set_mode(1'b1);
    do_read(12'h000);
    i_epp_prog_model.pulse_ctl(1'b1);
    check_flag("erase running", erase_busy, 1'b1);
    for (int i = 0; i < 5000 && erase_busy !== 1'b0; i++) @(posedge clk);
    #1 check_flag("erase finished", erase_busy, 1'b0);
    prot_exp = 1'b0;
    foreach (ref_mem[i]) ref_mem[i] = epp_pkg::ERASED_WORD;
    check_flag("cell after erase", protected_q, 1'b0);
    do_read(12'hFFF);
    do_read(used[3]);
    do_write(12'h555, 16'h3C3C);
    do_read(12'h555);
    final_report();
  end

  // about 5200 cycles expected; a generous margin before calling it a hang
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule
